// [rtl/power_current_limit_mode_pkg.sv]
package power_current_limit_mode_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HICCUP_ON_S = 1;
  localparam int unsigned HICCUP_ON_CYCLES = HICCUP_ON_S * CLK_HZ;
  localparam int unsigned FRAME_NS = 800;
  localparam int unsigned FRAME_CYCLES = (FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYCLES - 1);
  localparam logic [31:0] SENSE_SAMPLE = 32'(3 * FRAME_CYCLES - 1);
  localparam logic [31:0] SENSE_DONE = 32'(4 * FRAME_CYCLES - 1);
  localparam logic [31:0] FRAME2_START = 32'(2 * FRAME_CYCLES);
  localparam logic [7:0] PWM_LAST = 8'hff;

  // ****************************************************************
  // Register map, word index times four is the byte address
  // ****************************************************************
  localparam int NCFG = 14;
  localparam logic [3:0] I_CTRL = 4'h0;
  localparam logic [3:0] I_STATUS = 4'h1;
  localparam logic [3:0] I_POWER_LIMIT = 4'h2;
  localparam logic [3:0] I_CURRENT_LIMIT = 4'h3;
  localparam logic [3:0] I_PEAK_LIMIT = 4'h4;
  localparam logic [3:0] I_SHORT_LIMIT = 4'h5;
  localparam logic [3:0] I_FF_REF = 4'h6;
  localparam logic [3:0] I_BANDS = 4'h7;
  localparam logic [3:0] I_GAINS = 4'h8;
  localparam logic [3:0] I_REF_SETTING = 4'h9;
  localparam logic [3:0] I_HICCUP_IDLE = 4'ha;
  localparam logic [3:0] I_BURST_HOLD = 4'hb;
  localparam logic [3:0] I_VIN_START = 4'hc;
  localparam logic [3:0] I_BURST_DUTY = 4'hd;

  // Currents are in 1/16 A, power in watts, voltages in sense counts.
  localparam logic [31:0] CFG_RST [NCFG] = '{
    32'h0000_0002, 32'h0000_0000, 32'h0000_0168, 32'h0000_0240,
    32'h0000_0100, 32'h0000_0240, 32'h0000_0800, 32'h0040_0010,
    32'h2010_0100, 32'h0000_0800, 32'h0000_1000, 32'h0000_1000,
    32'h0000_0000, 32'h0000_c010};
  localparam logic [31:0] CFG_MASK [NCFG] = '{
    32'h0000_0007, 32'h0000_0000, 32'h0000_ffff, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_0fff, 32'h0fff_0fff,
    32'hffff_ffff, 32'h0000_0fff, 32'hffff_ffff, 32'hffff_ffff,
    32'h0000_0000, 32'h0000_ffff};

  localparam int CTRL_RUN = 0;
  localparam int CTRL_POWER_CURRENT_LIMIT_MODE = 1;
  localparam int CTRL_BURST = 2;
  localparam int CTRL_CLEAR = 3;

  // ****************************************************************
  // Fault and warning positions
  // ****************************************************************
  localparam int NFLT = 6;
  localparam int F_VOUT_OV = 0;
  localparam int F_VIN_OV = 1;
  localparam int F_VIN_UV = 2;
  localparam int F_IOUT_OC = 3;
  localparam int F_TEMP = 4;
  localparam int F_VOUT_UV = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    st_off, st_sense, st_run, st_hiccup_on, st_hiccup_idle, st_latched
  } state_t;

endpackage

// [rtl/converter_protection_feedforward.sv]
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module converter_protection_feedforward #(
  parameter int unsigned HICCUP_ON_CYCLES = power_current_limit_mode_pkg::HICCUP_ON_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Sensed quantities and loop filter outputs
  input wire logic [11:0] vin_sense,
  input wire logic [11:0] vout_sense,
  input wire logic [11:0] iout_sense,
  input wire logic [11:0] ipri_sense,
  input wire logic [7:0] v_filter,
  input wire logic [7:0] i_filter,
  // Fault and warning comparators
  input wire logic [5:0] fault_in,
  input wire logic [5:0] warn_in,
  // Power stage and supervision outputs
  output logic pwm_a,
  output logic pwm_b,
  output logic [15:0] ff_gain,
  output logic [11:0] vout_target,
  output logic [15:0] cc_setpoint,
  output logic current_loop_active,
  output logic burst_active,
  output logic bus_alert,
  output logic [7:0] status_byte
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  power_current_limit_mode_pkg::state_t state;
  logic [31:0] cfg [power_current_limit_mode_pkg::NCFG];
  logic aw_held, w_held, do_write, clear_req;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [5:0] flt, warn;
  logic cbc_seen, run_on, power_current_limit_mode_en, burst_en, flag_clear;
  logic [31:0] seq_cnt, heavy_cnt;
  logic [11:0] vin_start;
  logic [7:0] pwm_cnt, on_len, cmd;
  logic phase, trunc, over_peak, drive, burst_skip, period_start;
  logic hiccup_cause, latch_cause;
  logic signed [12:0] band_diff, ref_diff;
  logic [11:0] band_mag;
  logic signed [7:0] kp_sel;
  logic signed [20:0] ff_term;
  logic signed [21:0] gain_sum;
  logic [15:0] next_ff_gain, power;
  logic [23:0] duty_prod, pwr_prod;

  assign run_on = cfg[power_current_limit_mode_pkg::I_CTRL][power_current_limit_mode_pkg::CTRL_RUN];
  assign power_current_limit_mode_en = cfg[power_current_limit_mode_pkg::I_CTRL][power_current_limit_mode_pkg::CTRL_POWER_CURRENT_LIMIT_MODE];
  assign burst_en = cfg[power_current_limit_mode_pkg::I_CTRL][power_current_limit_mode_pkg::CTRL_BURST];

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  assign do_write = aw_held && w_held && !bvalid;
  assign next_aw_held = do_write ? 1'b0 : ((awvalid && awready) ? 1'b1 : aw_held);
  assign next_w_held = do_write ? 1'b0 : ((wvalid && wready) ? 1'b1 : w_held);
  assign next_bvalid = do_write ? 1'b1 : ((bvalid && bready) ? 1'b0 : bvalid);
  assign next_rvalid = (arvalid && arready) ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= power_current_limit_mode_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
      if (awvalid && awready) begin
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bresp <= (aw_addr[1:0] == 2'h0 && aw_addr[7:2] < 6'(power_current_limit_mode_pkg::NCFG)) ?
                 power_current_limit_mode_pkg::RESP_OKAY : power_current_limit_mode_pkg::RESP_SLVERR;
      end
    end
  end

  // Read-only words ignore writes; byte strobes merge into the old value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= power_current_limit_mode_pkg::CFG_RST;
      clear_req <= 1'b0;
    end else begin
      clear_req <= 1'b0;
      for (int i = 0; i < power_current_limit_mode_pkg::NCFG; i++) begin
        if (do_write && aw_addr[1:0] == 2'h0 && aw_addr[7:2] == 6'(i)) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
              cfg[i][8*b +: 8] <= w_data[8*b +: 8] & power_current_limit_mode_pkg::CFG_MASK[i][8*b +: 8];
            end
          end
          if (i == int'(power_current_limit_mode_pkg::I_CTRL) && w_strb[0]) begin
            clear_req <= w_data[power_current_limit_mode_pkg::CTRL_CLEAR];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= power_current_limit_mode_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (arvalid && arready) begin
        rresp <= power_current_limit_mode_pkg::RESP_OKAY;
        if (araddr[1:0] != 2'h0 || araddr[7:2] >= 6'(power_current_limit_mode_pkg::NCFG)) begin
          rdata <= 32'h0000_0000;
          rresp <= power_current_limit_mode_pkg::RESP_SLVERR;
        end else if (araddr[5:2] == power_current_limit_mode_pkg::I_STATUS) begin
          rdata <= {13'h0000, state, cbc_seen, burst_active, current_loop_active, 1'b0, warn, flt};
        end else if (araddr[5:2] == power_current_limit_mode_pkg::I_VIN_START) begin
          rdata <= {20'h00000, vin_start};
        end else begin
          rdata <= cfg[araddr[5:2]];
        end
      end
    end
  end

  // ****************************************************************
  // Fault and warning reporting
  // ****************************************************************
  // Dropping the run switch clears everything; a clear request is ignored while latched.
  assign flag_clear = !run_on || (clear_req && state != power_current_limit_mode_pkg::st_latched);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt <= 6'h00;
      warn <= 6'h00;
      cbc_seen <= 1'b0;
      bus_alert <= 1'b0;
      status_byte <= 8'h00;
    end else begin
      flt <= (flag_clear ? 6'h00 : flt) | fault_in;
      warn <= (flag_clear ? 6'h00 : warn) | warn_in;
      cbc_seen <= (flag_clear ? 1'b0 : cbc_seen) | over_peak;
      bus_alert <= |{flt, warn};
      status_byte <= {state == power_current_limit_mode_pkg::st_latched, |warn, flt};
    end
  end

  // ****************************************************************
  // Feed-forward multiplier
  // ****************************************************************
  always_comb begin
    band_diff = $signed({1'b0, vin_sense}) - $signed({1'b0, cfg[power_current_limit_mode_pkg::I_FF_REF][11:0]});
    band_mag = band_diff[12] ? 12'(-band_diff) : band_diff[11:0];
    ref_diff = $signed({1'b0, cfg[power_current_limit_mode_pkg::I_REF_SETTING][11:0]}) - $signed({1'b0, vin_sense});
    if (band_mag < cfg[power_current_limit_mode_pkg::I_BANDS][11:0]) begin
      kp_sel = 8'sh00;
    end else if (band_mag < cfg[power_current_limit_mode_pkg::I_BANDS][27:16]) begin
      kp_sel = $signed(cfg[power_current_limit_mode_pkg::I_GAINS][23:16]);
    end else begin
      kp_sel = $signed(cfg[power_current_limit_mode_pkg::I_GAINS][31:24]);
    end
    ff_term = kp_sel * ref_diff;
    gain_sum = $signed({6'h00, cfg[power_current_limit_mode_pkg::I_GAINS][15:0]}) + ff_term;
    if (gain_sum[21]) begin
      next_ff_gain = 16'h0000;
    end else if (|gain_sum[20:16]) begin
      next_ff_gain = 16'hffff;
    end else begin
      next_ff_gain = gain_sum[15:0];
    end
    // A heavy step during burst gets double the base gain to hold up the output.
    if (burst_active && v_filter > cfg[power_current_limit_mode_pkg::I_BURST_DUTY][15:8]) begin
      next_ff_gain = {cfg[power_current_limit_mode_pkg::I_GAINS][14:0], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff_gain <= 16'h0000;
    end else begin
      ff_gain <= next_ff_gain;
    end
  end

  // ****************************************************************
  // Loop arbitration and power limit
  // ****************************************************************
  assign duty_prod = v_filter * ff_gain;
  assign pwr_prod = vout_sense * iout_sense;
  assign power = pwr_prod[23:8];
  assign cmd = current_loop_active ? i_filter :
               (|duty_prod[23:16] ? 8'hff : duty_prod[15:8]);
  assign over_peak = ipri_sense > cfg[power_current_limit_mode_pkg::I_PEAK_LIMIT][11:0];
  assign period_start = pwm_cnt == 8'h00;
  assign latch_cause = flt[power_current_limit_mode_pkg::F_VOUT_OV] || fault_in[power_current_limit_mode_pkg::F_VOUT_OV];
  assign hiccup_cause = current_loop_active
                        || iout_sense > cfg[power_current_limit_mode_pkg::I_SHORT_LIMIT][11:0]
                        || fault_in[power_current_limit_mode_pkg::F_IOUT_OC] || fault_in[power_current_limit_mode_pkg::F_TEMP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_loop_active <= 1'b0;
      vout_target <= 12'h000;
      cc_setpoint <= 16'h0000;
    end else begin
      current_loop_active <= power_current_limit_mode_en && i_filter > v_filter;
      cc_setpoint <= cfg[power_current_limit_mode_pkg::I_CURRENT_LIMIT][15:0];
      if (!power_current_limit_mode_en) begin
        vout_target <= cfg[power_current_limit_mode_pkg::I_REF_SETTING][11:0];
      end else if (period_start) begin
        // Target walks one count per period; slower than a divide, but far cheaper.
        if (power > cfg[power_current_limit_mode_pkg::I_POWER_LIMIT][15:0] && vout_target != 12'h000) begin
          vout_target <= vout_target - 12'h001;
        end else if (vout_target < cfg[power_current_limit_mode_pkg::I_REF_SETTING][11:0]) begin
          vout_target <= vout_target + 12'h001;
        end else begin
          vout_target <= cfg[power_current_limit_mode_pkg::I_REF_SETTING][11:0];
        end
      end
    end
  end

  // ****************************************************************
  // Supervisory state machine
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= power_current_limit_mode_pkg::st_off;
      seq_cnt <= 32'h0000_0000;
      vin_start <= 12'h000;
    end else begin
      seq_cnt <= seq_cnt + 32'h0000_0001;
      if (!run_on) begin
        state <= power_current_limit_mode_pkg::st_off;
        seq_cnt <= 32'h0000_0000;
      end else begin
        case (state)
          power_current_limit_mode_pkg::st_off: begin
            state <= power_current_limit_mode_pkg::st_sense;
            seq_cnt <= 32'h0000_0000;
          end
          power_current_limit_mode_pkg::st_sense: begin
            if (seq_cnt == power_current_limit_mode_pkg::SENSE_SAMPLE) begin
              vin_start <= vin_sense;
            end
            if (latch_cause) begin
              state <= power_current_limit_mode_pkg::st_latched;
            end else if (seq_cnt == power_current_limit_mode_pkg::SENSE_DONE) begin
              state <= power_current_limit_mode_pkg::st_run;
            end
          end
          power_current_limit_mode_pkg::st_run: begin
            if (latch_cause) begin
              state <= power_current_limit_mode_pkg::st_latched;
            end else if (hiccup_cause) begin
              state <= power_current_limit_mode_pkg::st_hiccup_on;
              seq_cnt <= 32'h0000_0000;
            end
          end
          power_current_limit_mode_pkg::st_hiccup_on: begin
            if (latch_cause) begin
              state <= power_current_limit_mode_pkg::st_latched;
            end else if (seq_cnt >= 32'(HICCUP_ON_CYCLES - 1)) begin
              state <= power_current_limit_mode_pkg::st_hiccup_idle;
              seq_cnt <= 32'h0000_0000;
            end
          end
          power_current_limit_mode_pkg::st_hiccup_idle: begin
            if (latch_cause) begin
              state <= power_current_limit_mode_pkg::st_latched;
            end else if (seq_cnt >= cfg[power_current_limit_mode_pkg::I_HICCUP_IDLE]) begin
              state <= power_current_limit_mode_pkg::st_run;
            end
          end
          default: begin
            state <= power_current_limit_mode_pkg::st_latched;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Light-load burst
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_active <= 1'b0;
      heavy_cnt <= 32'h0000_0000;
      burst_skip <= 1'b0;
    end else begin
      if (!burst_en || state != power_current_limit_mode_pkg::st_run) begin
        burst_active <= 1'b0;
        heavy_cnt <= 32'h0000_0000;
      end else if (!burst_active) begin
        burst_active <= v_filter < cfg[power_current_limit_mode_pkg::I_BURST_DUTY][7:0];
        heavy_cnt <= 32'h0000_0000;
      end else if (v_filter > cfg[power_current_limit_mode_pkg::I_BURST_DUTY][15:8]) begin
        heavy_cnt <= heavy_cnt + 32'h0000_0001;
        if (heavy_cnt >= cfg[power_current_limit_mode_pkg::I_BURST_HOLD]) begin
          burst_active <= 1'b0;
        end
      end else begin
        heavy_cnt <= 32'h0000_0000;
      end
      if (period_start) begin
        burst_skip <= burst_active && vout_sense > vout_target;
      end
    end
  end

  // ****************************************************************
  // Pulse-width generator
  // ****************************************************************
  assign drive = (state == power_current_limit_mode_pkg::st_run || state == power_current_limit_mode_pkg::st_hiccup_on) && !burst_skip;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt <= 8'h00;
      on_len <= 8'h00;
      phase <= 1'b0;
      trunc <= 1'b0;
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
    end else begin
      pwm_cnt <= (pwm_cnt == power_current_limit_mode_pkg::PWM_LAST) ? 8'h00 : pwm_cnt + 8'h01;
      if (period_start) begin
        on_len <= cmd;
        phase <= !phase;
        trunc <= over_peak;
      end else begin
        trunc <= trunc | over_peak;
      end
      if (state == power_current_limit_mode_pkg::st_sense) begin
        pwm_a <= seq_cnt <= power_current_limit_mode_pkg::FRAME_LAST;
        pwm_b <= seq_cnt >= power_current_limit_mode_pkg::FRAME2_START && seq_cnt <= power_current_limit_mode_pkg::SENSE_SAMPLE;
      end else begin
        pwm_a <= drive && !phase && pwm_cnt < on_len && !trunc && !over_peak;
        pwm_b <= drive && phase && pwm_cnt < on_len && !trunc && !over_peak;
      end
    end
  end

endmodule

// [dv/power_stage_model.sv]
`timescale 1ns/1ns
module power_stage_model (
  // Clock
  input wire logic aclk,
  // Bridge legs and primary sensing
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic [11:0] slope,
  output logic [11:0] ipri_sense
);
  // Primary current ramps while a leg conducts and falls to zero between pulses.
  initial ipri_sense = 12'h000;
  always_ff @(posedge aclk) begin
    if (pwm_a || pwm_b) begin
      ipri_sense <= ipri_sense + slope;
    end else begin
      ipri_sense <= 12'h000;
    end
  end
endmodule

// [dv/converter_protection_feedforward_chk.sv]
`timescale 1ns/1ns
module converter_protection_feedforward_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sensing
  input wire logic [11:0] vin_sense,
  input wire logic [11:0] ipri_sense,
  input wire logic [7:0] v_filter,
  input wire logic [7:0] i_filter,
  input wire logic [5:0] fault_in,
  // Watched outputs
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic [15:0] ff_gain,
  input wire logic current_loop_active,
  input wire logic burst_active,
  input wire logic bus_alert,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Band limits hold only for the reset values of reference and bands.
  logic inner;
  assign inner = vin_sense > 12'h7f0 && vin_sense < 12'h810 && !burst_active && pwm_a;
  fault_sets_a: assert property (fault_in != 6'h00 |=> ##1
    (status_byte[5:0] & $past(fault_in, 2)) == $past(fault_in, 2)) else $error("fault bit lost");
  alert_mirror_a: assert property (
    bus_alert == (status_byte[6:0] != 7'h00)) else $error("alert mismatch");
  latch_quiet_a: assert property (status_byte[7] [*2] |-> !pwm_a && !pwm_b)
    else $error("pulses while latched");
  latch_cause_a: assert property ($rose(status_byte[7]) |-> status_byte[0])
    else $error("latched without overvoltage");
  peak_trunc_a: assert property (ipri_sense > 12'h100 |=> !pwm_a && !pwm_b)
    else $error("pulse not truncated");
  unity_gain_a: assert property (inner [*3] |-> ff_gain == 16'h0100)
    else $error("gain not unity");
  loop_select_a: assert property (current_loop_active |-> $past(i_filter) > $past(v_filter))
    else $error("current loop without cause");
  burst_gain_a: assert property ((burst_active && v_filter > 8'hc0) [*3] |->
    ff_gain == 16'h0200) else $error("burst gain wrong");
  cover property (status_byte[7]);
  cover property (current_loop_active);
  cover property (burst_active && v_filter > 8'hc0);
endmodule
bind converter_protection_feedforward converter_protection_feedforward_chk chk (.aclk,
  .aresetn, .vin_sense, .ipri_sense, .v_filter, .i_filter, .fault_in, .pwm_a, .pwm_b,
  .ff_gain, .current_loop_active, .burst_active, .bus_alert, .status_byte);

// [dv/converter_protection_feedforward_tb.sv]
`timescale 1ns/1ns
module converter_protection_feedforward_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, v_filter = 8'h80, i_filter = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, e;
  logic [3:0] wstrb = 4'hf;
  logic [11:0] vin_sense = 12'h808, vout_sense = 12'h400, iout_sense = 12'h010;
  logic [11:0] slope = 12'h001, ipri_sense, vout_target, t1;
  logic [5:0] fault_in = 6'h00, warn_in = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, pwm_a, pwm_b, hic;
  logic current_loop_active, burst_active, bus_alert;
  logic [1:0] bresp, rresp, r;
  logic [15:0] ff_gain, cc_setpoint;
  logic [7:0] status_byte;
  // Input levels and the multiplier each must select.
  logic [11:0] vt [4] = '{12'h808, 12'h7e0, 12'h830, 12'h7a0};
  logic [15:0] gt [4] = '{16'h0100, 16'h0300, 16'h0000, 16'h0d00};
  int n_mismatch = 0, cmp_count = 0, cyc = 0, w;

  // Short hiccup on-time keeps the run brief.
  converter_protection_feedforward #(.HICCUP_ON_CYCLES(200)) dut (.*);
  power_stage_model stage (.aclk, .pwm_a, .pwm_b, .slope, .ipri_sense);

  always #4 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        @(posedge aclk iff awready);
        awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff wready);
        wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk iff arready);
    arvalid <= 1'b0;
    @(posedge aclk iff rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] x);
    rd(a);
    chk(nm, d & m, x);
  endtask

  task automatic pulse(input logic b);
    @(posedge aclk iff !(b ? pwm_b : pwm_a));
    @(posedge aclk iff (b ? pwm_b : pwm_a));
    w = 0;
    while (b ? pwm_b : pwm_a) begin
      w++;
      @(posedge aclk);
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Currents count in sixteenths of an ampere.
    rchk("ctrl", 8'h00, 32'hf, 32'h2);
    rchk("power_lim", 8'h08, 32'hffff, 32'h168);
    rchk("current_lim", 8'h0c, 32'hffff, 32'h240);
    rchk("peak_lim", 8'h10, 32'hffff, 32'h100);
    rchk("short_lim", 8'h14, 32'hffff, 32'h240);
    rd(8'h38);
    chk("unmapped", {30'h0, r}, 32'h2);
    wr(8'h08, 32'h12c);
    rchk("power_lim", 8'h08, 32'hffff, 32'h12c);
    wr(8'h08, 32'h168);
    wr(8'h28, 32'h32);
    wr(8'h2c, 32'h40);
    fork
      wr(8'h00, 32'h3);
      pulse(1'b0);
    join
    chk("frame_a", w, 32'h64);
    pulse(1'b1);
    chk("frame_b", w, 32'h64);
    repeat (110) @(posedge aclk);
    rchk("state", 8'h04, 32'h7_0000, 32'h2_0000);
    rchk("vin_start", 8'h30, 32'hfff, 32'h808);
    chk("cc_setpoint", cc_setpoint, 32'h240);
    for (int i = 0; i < 4; i++) begin
      vin_sense <= vt[i];
      repeat (4) @(posedge aclk);
      chk("ff_gain", ff_gain, gt[i]);
    end
    vin_sense <= 12'h808;
    for (int k = 1; k < 8; k++) begin
      hic = k == 3 || k == 4 || k > 5;
      if (k < 6) fault_in <= 6'h01 << k;
      if (k == 6) iout_sense <= 12'h241;
      if (k == 7) i_filter <= 8'hff;
      repeat (2) @(posedge aclk);
      fault_in <= 6'h00;
      iout_sense <= 12'h010;
      i_filter <= 8'h00;
      e = (hic ? 32'h3_0000 : 32'h2_0000) | (k < 6 ? 32'h1 << k : 32'h0);
      rchk("fault_state", 8'h04, k < 6 ? 32'h7_003f : 32'h7_0000, e);
      if (k < 6) chk("alert", {31'h0, bus_alert}, 32'h1);
      if (hic) begin
        repeat (200) @(posedge aclk);
        rchk("idle", 8'h04, 32'h7_0000, 32'h4_0000);
        repeat (60) @(posedge aclk);
        rchk("retry", 8'h04, 32'h7_0000, 32'h2_0000);
      end
      wr(8'h00, 32'hb);
      rchk("cleared", 8'h04, 32'h7_0fff, 32'h2_0000);
    end
    wr(8'h00, 32'h1);
    i_filter <= 8'hff;
    repeat (4) @(posedge aclk);
    chk("loop_off", {31'h0, current_loop_active}, 32'h0);
    i_filter <= 8'h00;
    wr(8'h00, 32'h3);
    for (int k = 0; k < 6; k++) begin
      warn_in <= 6'h01 << k;
      @(posedge aclk);
      warn_in <= 6'h00;
      rchk("warning", 8'h04, 32'h7_0fff, 32'h2_0000 | 32'h40 << k);
      chk("warn_flag", {31'h0, status_byte[6]}, 32'h1);
      wr(8'h00, 32'hb);
    end
    slope <= 12'h040;
    pulse(1'b0);
    chk("trunc_width", w, 32'h6);
    slope <= 12'h001;
    rchk("limit_seen", 8'h04, 32'h7_8fff, 32'h2_8000);
    chk("no_alert", {31'h0, bus_alert}, 32'h0);
    iout_sense <= 12'h100;
    @(posedge aclk);
    t1 = vout_target;
    repeat (1024) @(posedge aclk);
    chk("target_low", {31'h0, vout_target < t1}, 32'h1);
    rchk("running", 8'h04, 32'h7_0000, 32'h2_0000);
    iout_sense <= 12'h010;
    v_filter <= 8'h08;
    repeat (600) @(posedge aclk);
    chk("burst_off", {31'h0, burst_active}, 32'h0);
    wr(8'h00, 32'h7);
    repeat (600) @(posedge aclk);
    chk("burst_on", {31'h0, burst_active}, 32'h1);
    v_filter <= 8'hd0;
    repeat (4) @(posedge aclk);
    chk("burst_gain", ff_gain, 32'h200);
    repeat (100) @(posedge aclk);
    chk("burst_left", {31'h0, burst_active}, 32'h0);
    v_filter <= 8'h80;
    fault_in <= 6'h01;
    repeat (2) @(posedge aclk);
    fault_in <= 6'h00;
    repeat (300) @(posedge aclk);
    wr(8'h00, 32'hb);
    rchk("latched", 8'h04, 32'h7_0001, 32'h5_0001);
    chk("quiet", {31'h0, pwm_a | pwm_b}, 32'h0);
    wr(8'h00, 32'h0);
    rchk("toggled", 8'h04, 32'h7_0fff, 32'h0);
    fork
      wr(8'h00, 32'h3);
      pulse(1'b0);
    join
    chk("restart", w, 32'h64);
    end_sim();
  end
endmodule
